/* File: src/dnc_pkg.sv */
// shared constants and types for the drive network command bank
package dnc_pkg;

	// ---------------------------------------------------------------
	// parameter indices
	// ---------------------------------------------------------------
	localparam logic [2:0] IDX_CMD_WORD  = 3'h0;
	localparam logic [2:0] IDX_SPEED_REF = 3'h1;
	localparam logic [2:0] IDX_DO_SET    = 3'h2;
	localparam logic [2:0] IDX_AO_ONE    = 3'h3;
	localparam logic [2:0] IDX_AO_TWO    = 3'h4;
	localparam logic [2:0] IDX_AO_THREE  = 3'h5;

	// ---------------------------------------------------------------
	// field layouts and reset values
	// ---------------------------------------------------------------
	localparam int         CMD_USED_W    = 8;
	localparam int         DO_USED_W     = 5;
	localparam int         AO_COUNT      = 3;
	localparam logic [15:0] CMD_RESET    = 16'h0000;
	localparam logic [15:0] WORD_RESET   = 16'h0000;
	localparam logic [15:0] DO_MAX       = 16'h001F;
	localparam logic [15:0] SPEED_RATED  = 16'h2000;
	localparam logic [15:0] SPEED_POS_MAX = 16'h7FFF;
	localparam logic [15:0] SPEED_NEG_MAX = 16'h8000;
	localparam logic [15:0] AO_FULL      = 16'h7FFF;

	// analog output function selection codes
	localparam logic [1:0] AO_SEL_NONE   = 2'h0;
	localparam logic [1:0] AO_SEL_ONE    = 2'h1;
	localparam logic [1:0] AO_SEL_TWO    = 2'h2;
	localparam logic [1:0] AO_SEL_THREE  = 2'h3;

	// command word bits, bit 0 last
	typedef struct packed {
		logic fault_reset;
		logic quick_stop;
		logic second_ramp;
		logic local_remote_select;
		logic inching_function;
		logic speed_direction;
		logic general_enable;
		logic run_stop;
	} dnc_cmd_s;

	typedef struct packed {
		logic        valid;
		logic        from_network;
		logic [2:0]  index;
		logic [15:0] data;
	} dnc_wr_s;

	typedef enum logic [1:0] {
		DNC_IDLE,
		DNC_FAULT_WAIT,
		DNC_RESET_SENT
	} dnc_frst_e;

endpackage

/* File: src/dnc_bank.sv */
// network-writable command parameter bank of a motor drive
`timescale 1ns/1ps
`default_nettype none

// How it works
// - 16-bit word resets to zero; network-only writes; 15..8 reserved.
// - command bits act only while command source is the network.
// - bit 0 low decelerates to stop, high accelerates toward reference.
// - bit 1 low disables drive and supply, high enables operation.
// - bit 2 high follows reference direction, low runs opposite.
// - bit 3 enables or disables the inching function.
// - bit 4 selects remote mode when set, local when clear.
// - bit 5 selects the second ramp time pair, else the first.
// - bit 6 quick stop, blocked in scalar or voltage vector control.
// - bit 7 high during a fault performs one fault reset.
// - speed reference signed, 2000h equals rated frequency, linear.
// - speed reference applied only when reference source is network; its sign feeds dir_forward_r under any reference source.
// - direction is reference sign combined with bit 2.
// - speed reference limited to four times synchronous speed.
// - output setting bits 0..4 close outputs one to five.
// - an output follows its bit only when its function selects it.
// - output setting writes accepted only from the network.
// - analog words: zero is 0 percent, 7FFFh is 100 percent.
// - analog output uses a word only when its selection names it.
// - analog words writable only from the network.
module dnc_bank
	import dnc_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	input  wire dnc_wr_s             wr_req,
	input  wire logic                rd_en,
	input  wire logic [2:0]          rd_index,
	input  wire logic                cmd_src_network,
	input  wire logic                ref_src_network,
	input  wire logic                scalar_or_vector_ctrl,
	input  wire logic                fault_active,
	input  wire logic [4:0]          do_func_uses_word,
	input  wire logic [5:0]          ao_func_sel,
	output logic [15:0]              rd_data_r,
	output logic                     rd_valid_r,
	output logic                     wr_refused_r,
	output logic                     run_accel_r,
	output logic                     drive_enable_r,
	output logic                     dir_forward_r,
	output logic                     inching_en_r,
	output logic                     remote_mode_r,
	output logic                     second_ramp_r,
	output logic                     quick_stop_r,
	output logic                     fault_reset_r,
	output logic [15:0]              speed_ref_r,
	output logic                     speed_ref_valid_r,
	output logic [4:0]               digital_out_r,
	output logic [4:0]               digital_out_net_r,
	output logic [47:0]              ao_level_r,
	output logic [2:0]               ao_net_r
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// network values already saturate at the word limits, so the
	// four-times bound coincides with the 16-bit range
	function automatic logic [15:0] speed_limit(input logic [15:0] v);
		logic signed [16:0] s;
		s = {v[15], v};
		if (s > $signed({1'b0, SPEED_POS_MAX}))
			speed_limit = SPEED_POS_MAX;
		else if (s < $signed({1'b1, SPEED_NEG_MAX}))
			speed_limit = SPEED_NEG_MAX;
		else
			speed_limit = v;
	endfunction

	// negative analog words mean below 0 percent; clamp to zero
	function automatic logic [15:0] ao_scale(input logic [15:0] v);
		ao_scale = v[15] ? WORD_RESET : (v & AO_FULL);
	endfunction

	// ---------------------------------------------------------------
	// parameter storage
	// ---------------------------------------------------------------
	dnc_cmd_s                cmd_r;
	logic [15:0]             speed_word_r;
	logic [DO_USED_W-1:0]    do_word_r;
	logic [15:0]             ao_word_r [AO_COUNT];
	logic                    wr_ok;
	dnc_frst_e               frst_r;
	logic                    frst_fire;

	// panel or other local sources see these words as read-only
	assign wr_ok = wr_req.valid & wr_req.from_network;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cmd_r <= dnc_cmd_s'(CMD_RESET[CMD_USED_W-1:0]);
		end else if (wr_ok && wr_req.index == IDX_CMD_WORD) begin
			cmd_r <= dnc_cmd_s'(wr_req.data[CMD_USED_W-1:0]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			speed_word_r <= WORD_RESET;
		end else if (wr_ok && wr_req.index == IDX_SPEED_REF) begin
			speed_word_r <= wr_req.data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			do_word_r <= WORD_RESET[DO_USED_W-1:0];
		end else if (wr_ok && wr_req.index == IDX_DO_SET) begin
			do_word_r <= wr_req.data[DO_USED_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < AO_COUNT; i++)
				ao_word_r[i] <= WORD_RESET;
		end else if (wr_ok) begin
			if (wr_req.index == IDX_AO_ONE)
				ao_word_r[0] <= wr_req.data;
			if (wr_req.index == IDX_AO_TWO)
				ao_word_r[1] <= wr_req.data;
			if (wr_req.index == IDX_AO_THREE)
				ao_word_r[2] <= wr_req.data;
		end
	end

	// local writes and writes to absent indices are flagged, not stored
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			wr_refused_r <= 1'b0;
		else
			wr_refused_r <= wr_req.valid &
				(!wr_req.from_network || wr_req.index > IDX_AO_THREE);
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rd_data_r  <= WORD_RESET;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en;
			case (rd_index)
			IDX_CMD_WORD:  rd_data_r <= {8'h00, cmd_r};
			IDX_SPEED_REF: rd_data_r <= speed_word_r;
			IDX_DO_SET:    rd_data_r <= {11'h000, do_word_r};
			IDX_AO_ONE:    rd_data_r <= ao_word_r[0];
			IDX_AO_TWO:    rd_data_r <= ao_word_r[1];
			IDX_AO_THREE:  rd_data_r <= ao_word_r[2];
			default:       rd_data_r <= WORD_RESET;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// drive commands
	// ---------------------------------------------------------------
	// with another command source the network bits are held off, but cmd_r
	// keeps the stale word, so it acts again when the source switches back
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			run_accel_r    <= 1'b0;
			drive_enable_r <= 1'b0;
			inching_en_r   <= 1'b0;
			remote_mode_r  <= 1'b0;
			second_ramp_r  <= 1'b0;
			quick_stop_r   <= 1'b0;
		end else begin
			run_accel_r    <= cmd_src_network & cmd_r.run_stop;
			drive_enable_r <= cmd_src_network & cmd_r.general_enable;
			inching_en_r   <= cmd_src_network & cmd_r.inching_function;
			remote_mode_r  <= cmd_src_network &
				cmd_r.local_remote_select;
			second_ramp_r  <= cmd_src_network & cmd_r.second_ramp;
			quick_stop_r   <= cmd_src_network & cmd_r.quick_stop &
				!scalar_or_vector_ctrl;
		end
	end

	// zero reference counts as positive for the direction decision
	always_ff @(posedge core_clk) begin
		if (!rst_b)
			dir_forward_r <= 1'b0;
		else if (cmd_src_network)
			dir_forward_r <= cmd_r.speed_direction ^ speed_word_r[15];
	end

	// one reset pulse per fault; holding the bit does not repeat it
	assign frst_fire = frst_r == DNC_FAULT_WAIT && fault_active &&
		cmd_src_network && cmd_r.fault_reset;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			frst_r <= DNC_IDLE;
		end else begin
			case (frst_r)
			DNC_IDLE:       if (fault_active) frst_r <= DNC_FAULT_WAIT;
			DNC_FAULT_WAIT: if (frst_fire) frst_r <= DNC_RESET_SENT;
				else if (!fault_active) frst_r <= DNC_IDLE;
			DNC_RESET_SENT: if (!fault_active) frst_r <= DNC_IDLE;
			default:        frst_r <= DNC_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			fault_reset_r <= 1'b0;
		else
			fault_reset_r <= frst_fire;
	end

	// ---------------------------------------------------------------
	// speed reference
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			speed_ref_r       <= WORD_RESET;
			speed_ref_valid_r <= 1'b0;
		end else begin
			speed_ref_valid_r <= ref_src_network;
			speed_ref_r       <= ref_src_network ?
				speed_limit(speed_word_r) : WORD_RESET;
		end
	end

	// ---------------------------------------------------------------
	// digital and analog outputs
	// ---------------------------------------------------------------
	// outputs not assigned to the word read open here; the owner of the
	// other function drives the real pin from its own source
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			digital_out_r     <= 5'h00;
			digital_out_net_r <= 5'h00;
		end else begin
			digital_out_r     <= do_word_r & do_func_uses_word;
			digital_out_net_r <= do_func_uses_word;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ao_level_r <= 48'h000000000000;
			ao_net_r   <= 3'h0;
		end else begin
			for (int k = 0; k < AO_COUNT; k++) begin
				case (ao_func_sel[2*k +: 2])
				AO_SEL_ONE:   ao_level_r[16*k +: 16] <= ao_scale(ao_word_r[0]);
				AO_SEL_TWO:   ao_level_r[16*k +: 16] <= ao_scale(ao_word_r[1]);
				AO_SEL_THREE: ao_level_r[16*k +: 16] <= ao_scale(ao_word_r[2]);
				default:      ao_level_r[16*k +: 16] <= WORD_RESET;
				endcase
				ao_net_r[k] <= ao_func_sel[2*k +: 2] != AO_SEL_NONE;
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	property p_local_write_refused;
		wr_req.valid && !wr_req.from_network && wr_req.index == IDX_CMD_WORD
		|=> $stable(cmd_r) && wr_refused_r;
	endproperty
	a_local_write_refused: assert property (p_local_write_refused)
		else $error("local write changed the command word");
	property p_cmd_gated;
		!cmd_src_network |=> !run_accel_r && !drive_enable_r && !quick_stop_r;
	endproperty
	a_cmd_gated: assert property (p_cmd_gated)
		else $error("command acted without network source");
	property p_run_follows;
		cmd_src_network && cmd_r.run_stop |=> run_accel_r;
	endproperty
	a_run_follows: assert property (p_run_follows)
		else $error("run bit not applied");
	property p_quick_stop_block;
		scalar_or_vector_ctrl |=> !quick_stop_r;
	endproperty
	a_quick_stop_block: assert property (p_quick_stop_block)
		else $error("quick stop in forbidden control type");
	property p_fault_reset_once;
		fault_reset_r |=> !fault_reset_r [*2];
	endproperty
	a_fault_reset_once: assert property (p_fault_reset_once)
		else $error("fault reset repeated");
	property p_fault_reset_cause;
		fault_reset_r |-> $past(fault_active) && $past(cmd_r.fault_reset);
	endproperty
	a_fault_reset_cause: assert property (p_fault_reset_cause)
		else $error("fault reset without fault and bit");
	property p_direction;
		cmd_src_network |=> dir_forward_r ==
			($past(cmd_r.speed_direction) ^ $past(speed_word_r[15]));
	endproperty
	a_direction: assert property (p_direction)
		else $error("wrong direction");
	property p_ref_gated;
		!ref_src_network |=> speed_ref_r == WORD_RESET && !speed_ref_valid_r;
	endproperty
	a_ref_gated: assert property (p_ref_gated)
		else $error("reference applied from wrong source");
	property p_do_gated;
		##1 (digital_out_r & ~digital_out_net_r) == 5'h00;
	endproperty
	a_do_gated: assert property (p_do_gated)
		else $error("digital output driven without selection");
	property p_do_write;
		wr_ok && wr_req.index == IDX_DO_SET
		|=> do_word_r == $past(wr_req.data[DO_USED_W-1:0]);
	endproperty
	a_do_write: assert property (p_do_write)
		else $error("digital output word not stored");
	property p_ao_range;
		ao_level_r[15:0] <= AO_FULL && ao_level_r[31:16] <= AO_FULL &&
			ao_level_r[47:32] <= AO_FULL;
	endproperty
	a_ao_range: assert property (p_ao_range)
		else $error("analog level above full scale");
	c_run: cover property (cmd_src_network && cmd_r.run_stop ##1 run_accel_r);
	c_fault_reset: cover property (fault_reset_r);
	c_refused: cover property (wr_refused_r);
	c_ao_net: cover property (ao_net_r == 3'h7);

endmodule

`default_nettype wire

/* File: verification/dnc_master_model.sv */
// fieldbus master model driving the bank's write and read ports
`timescale 1ns/1ps
`default_nettype none
module dnc_master_model
	import dnc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        wr_refused_r,
	input  wire logic        rd_valid_r,
	input  wire logic [15:0] rd_data_r,
	output var  dnc_wr_s     wr_req,
	output var  logic        rd_en,
	output var  logic [2:0]  rd_index
);
	initial begin
		wr_req = '0;
		rd_en = 1'b0;
		rd_index = 3'h0;
	end
	// net low lets a test pose as the local panel
	task automatic wr(input logic net, input logic [2:0] idx,
		input logic [15:0] d, output logic refused);
		@(posedge core_clk);
		#1 wr_req = '{1'b1, net, idx, d};
		@(posedge core_clk);
		#1 wr_req.valid = 1'b0;
		refused = wr_refused_r;
	endtask
	task automatic rd(input logic [2:0] idx, output logic [15:0] d,
		output logic v);
		@(posedge core_clk);
		#1 rd_en = 1'b1;
		rd_index = idx;
		@(posedge core_clk);
		#1 rd_en = 1'b0;
		d = rd_data_r;
		v = rd_valid_r;
	endtask
endmodule
`default_nettype wire

/* File: verification/test_dnc_bank.sv */
// self-checking bench for the drive network command bank
`timescale 1ns/1ps
`default_nettype none
module test_dnc_bank import dnc_pkg::*; ;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	dnc_wr_s     wr_req;
	logic        rd_en, cmd_net, ref_net, scalar, fault;
	logic [2:0]  rd_index, ao_net_r;
	logic [4:0]  do_func, digital_out_r, digital_out_net_r;
	logic [5:0]  ao_sel;
	logic [15:0] rd_data_r, speed_ref_r;
	logic [47:0] ao_level_r;
	logic        rd_valid_r, wr_refused_r, run_accel_r, drive_enable_r;
	logic        dir_forward_r, inching_en_r, remote_mode_r, second_ramp_r;
	logic        quick_stop_r, fault_reset_r, speed_ref_valid_r;
	int          bad_count = 0;
	int          check_count = 0;
	logic [7:0]  pulses;

	always #5 core_clk = ~core_clk;

	dnc_bank DUT (.core_clk(core_clk), .rst_b(rst_b), .wr_req(wr_req),
		.rd_en(rd_en), .rd_index(rd_index), .cmd_src_network(cmd_net),
		.ref_src_network(ref_net), .scalar_or_vector_ctrl(scalar),
		.fault_active(fault), .do_func_uses_word(do_func),
		.ao_func_sel(ao_sel), .rd_data_r(rd_data_r),
		.rd_valid_r(rd_valid_r), .wr_refused_r(wr_refused_r),
		.run_accel_r(run_accel_r), .drive_enable_r(drive_enable_r),
		.dir_forward_r(dir_forward_r), .inching_en_r(inching_en_r),
		.remote_mode_r(remote_mode_r), .second_ramp_r(second_ramp_r),
		.quick_stop_r(quick_stop_r), .fault_reset_r(fault_reset_r),
		.speed_ref_r(speed_ref_r), .speed_ref_valid_r(speed_ref_valid_r),
		.digital_out_r(digital_out_r),
		.digital_out_net_r(digital_out_net_r),
		.ao_level_r(ao_level_r), .ao_net_r(ao_net_r));

	dnc_master_model u_mst (.core_clk(core_clk),
		.wr_refused_r(wr_refused_r), .rd_valid_r(rd_valid_r),
		.rd_data_r(rd_data_r), .wr_req(wr_req), .rd_en(rd_en),
		.rd_index(rd_index));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic w(logic net, logic [2:0] i, logic [15:0] d, logic rf);
		logic got;
		u_mst.wr(net, i, d, got);
		chk(got, rf);
	endtask
	task automatic r(logic [2:0] i, logic [15:0] exp);
		logic [15:0] d;
		logic v;
		u_mst.rd(i, d, v);
		chk({v, d}, {1'b1, exp});
	endtask
	task automatic step(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// the pulse is one cycle wide, so every cycle is looked at
	task automatic count(int n);
		pulses = 0;
		repeat (n) begin
			@(posedge core_clk);
			#1 pulses += fault_reset_r;
		end
	endtask

	// hang guard: bounded run length
	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		results();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{cmd_net, ref_net, scalar, fault} = 4'b1000;
		do_func = 5'h00;
		ao_sel = 6'h00;
		repeat (8) @(posedge core_clk);
		#1 rst_b = 1'b1;
		r(IDX_CMD_WORD, CMD_RESET);
		w(1'b1, IDX_CMD_WORD, 16'hFF03, 1'b0);
		r(IDX_CMD_WORD, 16'h0003);
		step(1);
		chk({run_accel_r, drive_enable_r}, 2'b11);
		w(1'b0, IDX_CMD_WORD, 16'h00FF, 1'b1);
		r(IDX_CMD_WORD, 16'h0003);
		w(1'b1, 3'h6, 16'h1234, 1'b1);
		r(3'h7, 16'h0000);
		cmd_net = 1'b0;
		step(2);
		chk({run_accel_r, drive_enable_r}, 2'b00);
		cmd_net = 1'b1;
		w(1'b1, IDX_CMD_WORD, 16'h007C, 1'b0);
		step(2);
		chk({run_accel_r, drive_enable_r, inching_en_r, remote_mode_r,
			second_ramp_r, quick_stop_r, dir_forward_r}, 7'h1F);
		scalar = 1'b1;
		step(2);
		chk(quick_stop_r, 1'b0);
		scalar = 1'b0;
		w(1'b1, IDX_SPEED_REF, 16'hE000, 1'b0);
		step(2);
		chk({speed_ref_valid_r, speed_ref_r, dir_forward_r}, 18'h0);
		ref_net = 1'b1;
		step(2);
		chk({speed_ref_valid_r, speed_ref_r}, {1'b1, 16'hE000});
		w(1'b1, IDX_SPEED_REF, SPEED_POS_MAX, 1'b0);
		step(2);
		chk({speed_ref_r, dir_forward_r}, {SPEED_POS_MAX, 1'b1});
		w(1'b1, IDX_CMD_WORD, 16'h0003, 1'b0);
		step(2);
		chk(dir_forward_r, 1'b0);
		w(1'b1, IDX_SPEED_REF, SPEED_NEG_MAX, 1'b0);
		step(2);
		chk(dir_forward_r, 1'b1);
		fault = 1'b1;
		count(3);
		chk(pulses, 1'b0);
		w(1'b1, IDX_CMD_WORD, 16'h0080, 1'b0);
		count(6);
		chk(pulses, 1'b1);
		fault = 1'b0;
		count(4);
		chk(pulses, 1'b0);
		w(1'b1, IDX_DO_SET, 16'hFFF5, 1'b0);
		r(IDX_DO_SET, 16'h0015);
		do_func = 5'h0F;
		step(2);
		chk({digital_out_net_r, digital_out_r}, 10'h1E5);
		w(1'b0, IDX_DO_SET, 16'h0000, 1'b1);
		r(IDX_DO_SET, 16'h0015);
		w(1'b1, IDX_AO_ONE, AO_FULL, 1'b0);
		w(1'b1, IDX_AO_TWO, 16'h1234, 1'b0);
		w(1'b1, IDX_AO_THREE, 16'h8000, 1'b0);
		ao_sel = {AO_SEL_ONE, AO_SEL_THREE, AO_SEL_TWO};
		step(2);
		chk(ao_level_r, {AO_FULL, 16'h0000, 16'h1234});
		chk(ao_net_r, 3'b111);
		ao_sel = {AO_SEL_NONE, AO_SEL_ONE, AO_SEL_NONE};
		step(2);
		chk(ao_net_r, 3'b010);
		chk(ao_level_r, {16'h0000, AO_FULL, 16'h0000});
		w(1'b0, IDX_AO_ONE, 16'h0001, 1'b1);
		r(IDX_AO_ONE, AO_FULL);
		r(IDX_AO_THREE, 16'h8000);
		results();
	end
endmodule
`default_nettype wire
